// [rtl/ppc_port5.sv]
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Bit 0: one input, zero output
// - Bit 1 inverts pin value both ways
// - Bits 3:2 select function; 00 GPIO
// - Bit 7: one open-drain, zero push-pull
// - Pin 5.2: 10 IRQ5, 01 serial receive
// - Pin 5.2 config resets to 0x01
// - Pin 5.3 resets 0x00; IRQ7, serial transmit
// - Pin 5.4: 10 IRQ9, 01 data-set-ready
// - Pin 5.4 config resets to 0x01
module ppc_port5 (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       main_reset,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic [2:0] pad_in,
  output logic      [2:0] pad_out,
  output logic      [2:0] pad_oe,
  input  wire logic       second_serial_transmit_data,
  output logic            second_serial_receive_data,
  output logic            second_serial_data_set_ready_n,
  output logic            irq5,
  output logic            irq7,
  output logic            irq9
);

  typedef struct packed {
    logic [2:0] gpio_out;
    logic [7:0] rdata;
    logic [2:0] pad_out;
    logic [2:0] pad_oe;
    logic       rx;
    logic       dsr_n;
    logic       irq5;
    logic       irq7;
    logic       irq9;
  } ppc_state_s;

  ppc_state_s state;
  ppc_state_s next_state;

  logic [7:0] cfg2;
  logic [7:0] cfg3;
  logic [7:0] cfg4;
  logic [2:0] pad_out_d;
  logic [2:0] pad_oe_d;
  logic [2:0] level;

  // Standby-power reset covers all three; main-power and hard reset only pin 5.3
  ppc_cfg_reg #(.RESET_VAL(ppc_pkg::RST_PIN2_CFG)) u_cfg2 (
    .clk    (clk),
    .resetn (resetn),
    .clear  (1'b0),
    .we     (wr && addr == ppc_pkg::ADDR_PIN2_CFG),
    .wdata  (wdata),
    .q      (cfg2)
  );

  ppc_cfg_reg #(.RESET_VAL(ppc_pkg::RST_PIN3_CFG)) u_cfg3 (
    .clk    (clk),
    .resetn (resetn),
    .clear  (main_reset),
    .we     (wr && addr == ppc_pkg::ADDR_PIN3_CFG),
    .wdata  (wdata),
    .q      (cfg3)
  );

  ppc_cfg_reg #(.RESET_VAL(ppc_pkg::RST_PIN4_CFG)) u_cfg4 (
    .clk    (clk),
    .resetn (resetn),
    .clear  (1'b0),
    .we     (wr && addr == ppc_pkg::ADDR_PIN4_CFG),
    .wdata  (wdata),
    .q      (cfg4)
  );

  ppc_pin_cell #(.ALT_IS_OUTPUT(1'b0)) u_pin2 (
    .cfg        (cfg2),
    .gpio_level (state.gpio_out[0]),
    .alt_drive  (1'b0),
    .pad_in     (pad_in[0]),
    .pad_out_d  (pad_out_d[0]),
    .pad_oe_d   (pad_oe_d[0]),
    .core_level (level[0])
  );

  ppc_pin_cell #(.ALT_IS_OUTPUT(1'b1)) u_pin3 (
    .cfg        (cfg3),
    .gpio_level (state.gpio_out[1]),
    .alt_drive  (second_serial_transmit_data),
    .pad_in     (pad_in[1]),
    .pad_out_d  (pad_out_d[1]),
    .pad_oe_d   (pad_oe_d[1]),
    .core_level (level[1])
  );

  ppc_pin_cell #(.ALT_IS_OUTPUT(1'b0)) u_pin4 (
    .cfg        (cfg4),
    .gpio_level (state.gpio_out[2]),
    .alt_drive  (1'b0),
    .pad_in     (pad_in[2]),
    .pad_out_d  (pad_out_d[2]),
    .pad_oe_d   (pad_oe_d[2]),
    .core_level (level[2])
  );

  always_comb begin
    next_state         = state;
    next_state.pad_out = pad_out_d;
    next_state.pad_oe  = pad_oe_d;
    // Unselected alternates sit at their idle level
    next_state.rx    = (ppc_pkg::ppc_alt(cfg2) == ppc_pkg::ALT_SERIAL) ? level[0] : 1'b1;
    next_state.irq5  = (ppc_pkg::ppc_alt(cfg2) == ppc_pkg::ALT_IRQ) && level[0];
    next_state.irq7  = (ppc_pkg::ppc_alt(cfg3) == ppc_pkg::ALT_IRQ) && level[1];
    next_state.dsr_n = (ppc_pkg::ppc_alt(cfg4) == ppc_pkg::ALT_SERIAL) ? level[2] : 1'b1;
    next_state.irq9  = (ppc_pkg::ppc_alt(cfg4) == ppc_pkg::ALT_IRQ) && level[2];
    if (wr && addr == ppc_pkg::ADDR_DATA_OUT) begin
      next_state.gpio_out = wdata[2:0];
    end
    next_state.rdata = ppc_pkg::RST_RDATA;
    if (rd) begin
      case (addr)
        ppc_pkg::ADDR_PIN2_CFG:  next_state.rdata = cfg2;
        ppc_pkg::ADDR_PIN3_CFG:  next_state.rdata = cfg3;
        ppc_pkg::ADDR_PIN4_CFG:  next_state.rdata = cfg4;
        ppc_pkg::ADDR_DATA_OUT:  next_state.rdata = {5'h00, state.gpio_out};
        ppc_pkg::ADDR_PIN_LEVEL: next_state.rdata = {5'h00, level};
        default:                 next_state.rdata = ppc_pkg::RST_RDATA;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= '{gpio_out: ppc_pkg::RST_DATA_OUT, rdata: ppc_pkg::RST_RDATA,
                 pad_out: 3'h0, pad_oe: 3'h0, rx: 1'b1, dsr_n: 1'b1,
                 irq5: 1'b0, irq7: 1'b0, irq9: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  assign rdata                          = state.rdata;
  assign pad_out                        = state.pad_out;
  assign pad_oe                         = state.pad_oe;
  assign second_serial_receive_data     = state.rx;
  assign second_serial_data_set_ready_n = state.dsr_n;
  assign irq5                           = state.irq5;
  assign irq7                           = state.irq7;
  assign irq9                           = state.irq9;

endmodule
`default_nettype wire

// [rtl/ppc_pkg.sv]
`default_nettype none
package ppc_pkg;

  localparam logic [7:0] ADDR_PIN2_CFG  = 8'h41;
  localparam logic [7:0] ADDR_PIN3_CFG  = 8'h42;
  localparam logic [7:0] ADDR_PIN4_CFG  = 8'h43;
  localparam logic [7:0] ADDR_DATA_OUT  = 8'h50;
  localparam logic [7:0] ADDR_PIN_LEVEL = 8'h51;

  localparam logic [7:0] RST_PIN2_CFG   = 8'h01;
  localparam logic [7:0] RST_PIN3_CFG   = 8'h00;
  localparam logic [7:0] RST_PIN4_CFG   = 8'h01;
  localparam logic [2:0] RST_DATA_OUT   = 3'h0;
  localparam logic [7:0] RST_RDATA      = 8'h00;

  localparam int         DIR_BIT        = 0;
  localparam int         POL_BIT        = 1;
  localparam int         ALT_LSB        = 2;
  localparam int         ODRAIN_BIT     = 7;
  localparam logic [7:0] CFG_WRITE_MASK = 8'h8F;

  typedef enum logic [1:0] {
    ALT_GPIO     = 2'b00,
    ALT_SERIAL   = 2'b01,
    ALT_IRQ      = 2'b10,
    ALT_RESERVED = 2'b11
  } ppc_alt_e;

  function automatic ppc_alt_e ppc_alt(input logic [7:0] cfg);
    ppc_alt = ppc_alt_e'(cfg[ALT_LSB+1:ALT_LSB]);
  endfunction

endpackage
`default_nettype wire

// [rtl/ppc_cfg_reg.sv]
`timescale 1ns/1ps
`default_nettype none
module ppc_cfg_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       clear,
  input  wire logic       we,
  input  wire logic [7:0] wdata,
  output logic      [7:0] q
);

  typedef struct packed {
    logic [7:0] cfg;
  } ppc_cfg_s;

  ppc_cfg_s state;
  ppc_cfg_s next_state;

  // A reset value software could never write back would break readback
  if ((RESET_VAL & ~ppc_pkg::CFG_WRITE_MASK) != 8'h00 ||
      RESET_VAL[ppc_pkg::ALT_LSB+1:ppc_pkg::ALT_LSB] == 2'h3) begin : g_bad_reset
    $error("Reset value uses reserved bits or the reserved select");
  end

  always_comb begin
    next_state = state;
    if (clear) begin
      next_state.cfg = RESET_VAL;
    end else if (we) begin
      next_state.cfg = wdata & ppc_pkg::CFG_WRITE_MASK;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= '{cfg: RESET_VAL};
    end else begin
      state <= next_state;
    end
  end

  assign q = state.cfg;

endmodule
`default_nettype wire

// [rtl/ppc_pin_cell.sv]
`timescale 1ns/1ps
`default_nettype none
module ppc_pin_cell #(
  parameter bit ALT_IS_OUTPUT = 1'b0
) (
  input  wire logic [7:0] cfg,
  input  wire logic       gpio_level,
  input  wire logic       alt_drive,
  input  wire logic       pad_in,
  output logic            pad_out_d,
  output logic            pad_oe_d,
  output logic            core_level
);

  ppc_pkg::ppc_alt_e alt;
  logic              invert;
  logic              src;
  logic              val;
  logic              drive;

  always_comb begin
    alt    = ppc_pkg::ppc_alt(cfg);
    invert = cfg[ppc_pkg::POL_BIT];
    // Reserved select falls back to plain GPIO
    src    = (alt == ppc_pkg::ALT_SERIAL && ALT_IS_OUTPUT) ? alt_drive : gpio_level;
    val    = src ^ invert;
    // Input-type alternates never drive the pad
    drive  = !cfg[ppc_pkg::DIR_BIT] && (alt != ppc_pkg::ALT_IRQ) &&
             !(alt == ppc_pkg::ALT_SERIAL && !ALT_IS_OUTPUT);
    if (cfg[ppc_pkg::ODRAIN_BIT]) begin
      pad_out_d = 1'b0;
      pad_oe_d  = drive && !val;
    end else begin
      pad_out_d = val;
      pad_oe_d  = drive;
    end
    core_level = pad_in ^ invert;
  end

endmodule
`default_nettype wire

// [tb/ppc_port5_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module ppc_port5_props (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       main_reset,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic [2:0] pad_in,
  input wire logic [2:0] pad_out,
  input wire logic [2:0] pad_oe,
  input wire logic       second_serial_transmit_data,
  input wire logic       second_serial_receive_data,
  input wire logic       irq5,
  input wire logic       irq7
);
  logic [7:0] c2, c3;
  // Shadow configs, loaded on the same edge as the design's
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      c2 <= 8'h01;
      c3 <= 8'h00;
    end else begin
      if (wr && addr == 8'h41) c2 <= wdata & 8'h8F;
      if (wr && addr == 8'h42) c3 <= wdata & 8'h8F;
      if (main_reset) c3 <= 8'h00;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("rdata not idle");
  a_cfg3_read: assert property ($past(rd) && $past(addr) == 8'h42 |-> rdata == $past(c3))
    else $error("cfg3 readback");
  a_irq5_path: assert property (irq5 == ($past(c2[3:2]) == 2'h2 && ($past(pad_in[0]) ^ $past(c2[1]))))
    else $error("irq5");
  a_rx_path: assert property (second_serial_receive_data == ($past(c2[3:2]) == 2'h1 ?
    $past(pad_in[0]) ^ $past(c2[1]) : 1'h1)) else $error("rx");
  a_irq7_path: assert property (irq7 == ($past(c3[3:2]) == 2'h2 && ($past(pad_in[1]) ^ $past(c3[1]))))
    else $error("irq7");
  a_dir_input: assert property ((pad_oe[1:0] & {$past(c3[0]), $past(c2[0])}) == 2'h0)
    else $error("input driven");
  a_odrain_low: assert property ($past(c3[7]) |-> !pad_out[1])
    else $error("open drain high");
  a_tx_drive: assert property (($past(c3) & 8'h8D) == 8'h04 |-> pad_oe[1] &&
    pad_out[1] == ($past(second_serial_transmit_data) ^ $past(c3[1]))) else $error("tx");
  cover property (irq5);
  cover property ($past(main_reset));
  cover property (pad_oe[1] && $past(c3[3:2]) == 2'h1);
endmodule
bind ppc_port5 ppc_port5_props chk_u (.clk, .resetn, .main_reset, .addr, .wdata, .wr, .rd, .rdata, .pad_in,
  .pad_out, .pad_oe, .second_serial_transmit_data, .second_serial_receive_data, .irq5, .irq7);
`default_nettype wire

// [tb/tb_ppc_port5.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_ppc_port5;
  logic       clk, resetn, main_reset, wr, rd, tx;
  logic [7:0] addr, wdata, rdata, d;
  logic [2:0] pad_in, pad_out, pad_oe, lv;
  logic [3:0] i;
  logic       rx, dsr_n, irq5, irq7, irq9;
  logic [2:0] eo, ep, pl;
  logic       src, val, drv;
  int         err_count, checked;
  int         m [3];
  initial {clk, resetn, main_reset, wr, rd, tx, addr, wdata, pad_in} = '0;
  always #4 clk = ~clk;
  ppc_port5 dut_u (.clk, .resetn, .main_reset, .addr, .wdata, .wr, .rd, .rdata, .pad_in, .pad_out, .pad_oe,
    .second_serial_transmit_data(tx), .second_serial_receive_data(rx),
    .second_serial_data_set_ready_n(dsr_n), .irq5, .irq7, .irq9);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Write, or read and compare the byte of the following cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= w;
    rd    <= !w;
    @(posedge clk);
    wr <= 1'h0;
    rd <= 1'h0;
    if (!w) begin
      @(negedge clk);
      chk(rdata, v);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    err_count++;
    final_report;
  end
  initial begin
    d = 8'($urandom(7023));
    repeat (12) @(posedge clk);
    resetn <= 1'h1;
    // Pin 5.3 comes out of reset as a push-pull output driving low
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({2'h0, pad_oe, pad_out}, 8'h10);
    m = '{1, 0, 1};
    // First pass reads the reset values
    repeat (9) begin
      for (int k = 0; k < 3; k++) bus(1'h0, 8'(8'h41 + k), 8'(m[k]));
      for (int k = 0; k < 3; k++) begin
        d = 8'($urandom);
        d[3] = d[3] & ~d[2];
        m[k] = d & 8'h8F;
        bus(1'h1, 8'(8'h41 + k), d);
      end
    end
    bus(1'h1, 8'h60, 8'hFF);
    bus(1'h0, 8'h60, 8'h00);
    $display("t1 registers");
    for (int k = 0; k < 6; k++) begin
      d = {4'h0, 2'(k >> 1), k[0], 1'h1};
      for (int n = 0; n < 3; n++) bus(1'h1, 8'(8'h41 + n), d);
      pad_in <= 3'($urandom);
      repeat (3) @(posedge clk);
      @(negedge clk);
      lv = pad_in ^ {3{d[1]}};
      chk({pad_oe, irq9, irq7, irq5, dsr_n, rx}, {3'h0, lv & {3{d[3]}}, d[2] ? {lv[2], lv[0]} : 2'h3});
    end
    $display("t2 alternates");
    for (int k = 0; k < 16; k++) begin
      i = 4'(k);
      bus(1'h1, 8'h42, {i[0], 4'h0, i[3], i[1], 1'h0});
      bus(1'h1, 8'h50, {6'h0, i[2], 1'h0});
      tx <= ~i[2];
      repeat (2) @(posedge clk);
      @(negedge clk);
      lv[0] = ^i[3:1];
      chk({6'h0, pad_oe[1], pad_out[1]}, {6'h0, i[0] ? {~lv[0], 1'h0} : {1'h1, lv[0]}});
    end
    $display("t3 drivers");
    // Random pin setups against the bench's own driver model
    for (int k = 0; k < 24; k++) begin
      for (int n = 0; n < 3; n++) begin
        d = 8'($urandom);
        d[3] = d[3] & ~d[2];
        m[n] = d & 8'h8F;
        bus(1'h1, 8'(8'h41 + n), d);
      end
      lv = 3'($urandom);
      bus(1'h1, 8'h50, {5'h00, lv});
      tx <= 1'($urandom);
      pad_in <= 3'($urandom);
      repeat (2) @(posedge clk);
      @(negedge clk);
      for (int n = 0; n < 3; n++) begin
        d = 8'(m[n]);
        pl[n] = d[1];
        src = (n == 1 && d[3:2] == 2'h1) ? tx : lv[n];
        val = src ^ d[1];
        drv = !d[0] && d[3:2] != 2'h2 && !(d[3:2] == 2'h1 && n != 1);
        eo[n] = d[7] ? drv && !val : drv;
        ep[n] = d[7] ? 1'h0 : val;
      end
      chk({2'h0, pad_oe, pad_out}, {2'h0, eo, ep});
      bus(1'h0, 8'h50, {5'h00, lv});
      bus(1'h0, 8'h51, {5'h00, pad_in ^ pl});
    end
    $display("t4 outputs");
    bus(1'h1, 8'h42, 8'h85);
    bus(1'h1, 8'h41, 8'h80);
    main_reset <= 1'h1;
    @(posedge clk);
    main_reset <= 1'h0;
    bus(1'h0, 8'h42, 8'h00);
    bus(1'h0, 8'h41, 8'h80);
    // Standby-power reset in mid-run restores every register
    @(posedge clk);
    resetn <= 1'h0;
    repeat (2) @(posedge clk);
    resetn <= 1'h1;
    bus(1'h0, 8'h41, 8'h01);
    bus(1'h0, 8'h43, 8'h01);
    bus(1'h0, 8'h50, 8'h00);
    $display("t5 resets");
    final_report;
  end
endmodule
`default_nettype wire
